// ### core/dic_config_reg.sv
/*
 * Drive interface configuration register 0 with the logic it steers:
 * transfer mode, DMA direction check, last-packet write pause and the
 * view select for the shared byte-count addresses.
 * Assumes the MCU external data bus: a 16-bit address with one-cycle
 * read and write strobes, synchronous to ref_clk. The two byte counts
 * and the write-transfer signals come from the surrounding bridge.
 */
// Notes on behaviour
// - Power-up or watchdog reset clears the whole register to zero.
// - A USB bus reset leaves every bit of the register as it was.
// - Bit 7 picks USB counts (0) or drive counts (1) at the shared reads.
// - Bits 1:0 pick PIO 00, multiword DMA 01, Ultra DMA 11; 10 reserved.
// - With bit 2 set, directions are compared before a packet DMA phase.
// - A direction mismatch aborts the phase and raises the sequence error.
// - The direction check enable is ignored for non-packet drives.
// - Writes pause before the last USB packet and wait for firmware.
// - With bit 3 set, firmware may abort and flush the last packet.
// - With bit 3 clear, firmware may only move all data to the drive.
`default_nettype none

module dic_config_reg (
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        wdt_reset,
   input  wire logic        usb_reset,
   // MCU external data port
   input  wire logic [15:0] xaddr,
   input  wire logic        xwr,
   input  wire logic        xrd,
   input  wire logic [7:0]  xwdata,
   output logic      [7:0]  xrdata,
   output logic             xrdata_valid,
   // Byte counts sharing the four addresses
   input  wire logic [31:0] usb_byte_count,
   input  wire logic [31:0] drive_byte_count,
   // Configuration fields to the bridge
   output logic      [1:0]  transfer_mode_select,
   output logic             dma_direction_check_enable,
   output logic             write_pending_abort_enable,
   output logic             byte_count_view_select,
   // Direction check
   input  wire logic        dma_start_req,
   input  wire logic        is_packet_drive,
   input  wire logic        own_dir_in,
   input  wire logic        drive_dir_in,
   output logic             dma_start_ok,
   output logic             dma_xfer_abort,
   output logic             dma_sequence_error_flag,
   // Last-packet write pause
   input  wire logic        wr_xfer_active,
   input  wire logic        last_packet_ready,
   input  wire logic        fw_move_req,
   input  wire logic        fw_abort_req,
   output logic             wr_pending,
   output logic             move_last_packet,
   output logic             flush_last_packet,
   output logic             wr_xfer_abort
);

   typedef struct packed {
      logic                  view_sel;
      logic                  wpa_en;
      logic                  dir_en;
      logic [1:0]            mode;
      logic [7:0]            rdata;
      logic                  rvalid;
      dic_pkg::dic_wp_e      wp;
      logic                  move;
      logic                  flush;
      logic                  wabort;
   } dic_cfg_s;

   dic_cfg_s st;
   dic_cfg_s next_st;
   logic [7:0] cfg_value;
   logic       wr_hit;
   logic [1:0] bc_index;

   // ------------------------------------------------------------------
   // Register view and decode
   // ------------------------------------------------------------------
   // Reserved bits are not stored at all, so they always read zero
   assign cfg_value = {st.view_sel, 3'h0, st.wpa_en, st.dir_en,
                       st.mode};
   assign wr_hit    = xwr && (xaddr == dic_pkg::ADDR_CFG0);
   assign bc_index  = 2'(xaddr - dic_pkg::ADDR_BC0);

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   always_comb begin
      logic [31:0] bc_sel;
      bc_sel  = 32'h0000_0000;
      next_st = st;
      next_st.move   = 1'b0;
      next_st.flush  = 1'b0;
      next_st.wabort = 1'b0;
      next_st.rvalid = 1'b0;

      // Register write; usb_reset is deliberately not looked at
      if (wr_hit) begin
         next_st.view_sel = xwdata[dic_pkg::BIT_VIEW_SEL];
         next_st.wpa_en   = xwdata[dic_pkg::BIT_WPA_EN];
         next_st.dir_en   = xwdata[dic_pkg::BIT_DIR_EN];
         next_st.mode     = xwdata[dic_pkg::BIT_MODE_HI:
                                   dic_pkg::BIT_MODE_LO];
      end

      // Read path: the view bit steers the shared count addresses
      bc_sel = st.view_sel ? drive_byte_count : usb_byte_count;
      if (xrd) begin
         next_st.rvalid = 1'b1;
         if (xaddr == dic_pkg::ADDR_CFG0) begin
            next_st.rdata = cfg_value;
         end else if (xaddr >= dic_pkg::ADDR_BC0
                      && xaddr <= dic_pkg::ADDR_BC3) begin
            next_st.rdata = bc_sel[8*bc_index +: 8];
         end else begin
            next_st.rdata = dic_pkg::RDATA_IDLE;
         end
      end

      // Last-packet write sequencer
      case (st.wp)
         dic_pkg::WP_IDLE: begin
            if (wr_xfer_active) begin
               next_st.wp = dic_pkg::WP_MOVING;
            end
         end
         dic_pkg::WP_MOVING: begin
            // Hold the last packet back until firmware decides
            if (last_packet_ready) begin
               next_st.wp = dic_pkg::WP_PAUSED;
            end
         end
         dic_pkg::WP_PAUSED: begin
            if (fw_abort_req && st.wpa_en) begin
               next_st.flush  = 1'b1;
               next_st.wabort = 1'b1;
               next_st.wp     = dic_pkg::WP_DRAIN;
            end else if (fw_move_req) begin
               // Mover then runs to the host's requested length
               next_st.move = 1'b1;
               next_st.wp   = dic_pkg::WP_DRAIN;
            end
         end
         dic_pkg::WP_DRAIN: begin
            // Stay here so one transfer pauses only once
         end
         default: begin
            next_st.wp = dic_pkg::WP_IDLE;
         end
      endcase
      if (!wr_xfer_active && st.wp != dic_pkg::WP_IDLE) begin
         next_st.wp = dic_pkg::WP_IDLE;
      end

      // Watchdog clears the configuration like a power-up
      if (wdt_reset) begin
         next_st.view_sel = dic_pkg::CFG0_RESET[dic_pkg::BIT_VIEW_SEL];
         next_st.wpa_en   = dic_pkg::CFG0_RESET[dic_pkg::BIT_WPA_EN];
         next_st.dir_en   = dic_pkg::CFG0_RESET[dic_pkg::BIT_DIR_EN];
         next_st.mode     = dic_pkg::CFG0_RESET[dic_pkg::BIT_MODE_HI:
                                                dic_pkg::BIT_MODE_LO];
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st       <= '0;
         st.wp    <= dic_pkg::WP_IDLE;
         st.rdata <= dic_pkg::RDATA_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign xrdata                     = st.rdata;
   assign xrdata_valid               = st.rvalid;
   assign transfer_mode_select       = st.mode;
   assign dma_direction_check_enable = st.dir_en;
   assign write_pending_abort_enable = st.wpa_en;
   assign byte_count_view_select     = st.view_sel;
   assign wr_pending                 = (st.wp == dic_pkg::WP_PAUSED);
   assign move_last_packet           = st.move;
   assign flush_last_packet          = st.flush;
   assign wr_xfer_abort              = st.wabort;

   // Direction check unit for packet-drive DMA phases
   dic_dir_check u_dir_check (
      .ref_clk         (ref_clk),
      .reset           (reset),
      .start_req       (dma_start_req),
      .is_packet_drive (is_packet_drive),
      .check_enable    (st.dir_en),
      .own_dir_in      (own_dir_in),
      .drive_dir_in    (drive_dir_in),
      .start_ok        (dma_start_ok),
      .xfer_abort      (dma_xfer_abort),
      .seq_error_set   (dma_sequence_error_flag)
   );

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   wdt_clear_a: assert property (
      wdt_reset |=> cfg_value == dic_pkg::CFG0_RESET)
      else $error("watchdog did not clear the register");

   usb_keep_a: assert property (
      usb_reset && !wdt_reset && !wr_hit |=> $stable(cfg_value))
      else $error("usb reset changed the register");

   view_read_a: assert property (
      xrd && xaddr == dic_pkg::ADDR_BC0 && !st.view_sel
      |=> xrdata_valid && xrdata == $past(usb_byte_count[7:0]))
      else $error("count view read wrong byte");

   mode_write_a: assert property (
      wr_hit && !wdt_reset
      |=> transfer_mode_select == $past(xwdata[1:0]))
      else $error("mode field not written");

   rsv_zero_a: assert property (
      xrd && xaddr == dic_pkg::ADDR_CFG0 |=> xrdata[6:4] == 3'h0)
      else $error("reserved bits read nonzero");

   pause_hold_a: assert property (
      wr_pending && wr_xfer_active && !fw_move_req
      && !(fw_abort_req && st.wpa_en) |=> wr_pending)
      else $error("pause released without firmware");

   flush_a: assert property (
      wr_pending && wr_xfer_active && fw_abort_req && st.wpa_en
      |=> flush_last_packet && wr_xfer_abort ##1 !flush_last_packet)
      else $error("abort did not flush");

   no_abort_a: assert property (
      wr_pending && fw_abort_req && !st.wpa_en
      |=> !flush_last_packet && !wr_xfer_abort)
      else $error("abort honoured while disabled");

   // Field writes land one cycle after the strobe unless watchdog wins
   view_write_a: assert property (
      wr_hit && !wdt_reset
      |=> byte_count_view_select == $past(xwdata[dic_pkg::BIT_VIEW_SEL]))
      else $error("view bit not written");

   dir_write_a: assert property (
      wr_hit && !wdt_reset
      |=> dma_direction_check_enable == $past(xwdata[dic_pkg::BIT_DIR_EN]))
      else $error("direction check enable not written");

   wpa_write_a: assert property (
      wr_hit && !wdt_reset
      |=> write_pending_abort_enable == $past(xwdata[dic_pkg::BIT_WPA_EN]))
      else $error("abort enable not written");

   drive_view_a: assert property (
      xrd && xaddr == dic_pkg::ADDR_BC3 && st.view_sel
      |=> xrdata_valid && xrdata == $past(drive_byte_count[31:24]))
      else $error("drive count view read wrong byte");

   // Read strobe answers exactly one cycle later, for one cycle only
   read_valid_a: assert property (
      xrd |=> xrdata_valid)
      else $error("read not answered");

   valid_pulse_a: assert property (
      !xrd |=> !xrdata_valid)
      else $error("read valid without a read");

   pause_entry_a: assert property (
      st.wp == dic_pkg::WP_MOVING && wr_xfer_active && last_packet_ready
      |=> wr_pending)
      else $error("last packet did not pause");

   move_pulse_a: assert property (
      wr_pending && wr_xfer_active && fw_move_req
      && !(fw_abort_req && st.wpa_en)
      |=> move_last_packet && !flush_last_packet && !wr_pending)
      else $error("move decision not carried out");

   pause_c: cover property (wr_pending ##[1:20] move_last_packet);
   flush_c: cover property (flush_last_packet);
   view_c:  cover property (xrd && st.view_sel
                            && xaddr == dic_pkg::ADDR_BC3);

endmodule

`default_nettype wire

// ### core/dic_dir_check.sv
/*
 * DMA direction check unit. Before a packet-drive DMA data phase starts
 * it compares the bridge's own direction with the drive's and either
 * lets the phase start or aborts it and raises the sequence error.
 * Assumes start requests are one-cycle pulses from the transaction
 * sequencer and the directions are stable while a request is high.
 */
`default_nettype none

module dic_dir_check (
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic start_req,
   input  wire logic is_packet_drive,
   input  wire logic check_enable,
   input  wire logic own_dir_in,
   input  wire logic drive_dir_in,
   output logic      start_ok,
   output logic      xfer_abort,
   output logic      seq_error_set
);

   typedef struct packed {
      logic ok;
      logic abort;
      logic err;
   } dic_dc_s;

   dic_dc_s st;
   dic_dc_s next_st;

   // ------------------------------------------------------------------
   // Decision for each start request
   // ------------------------------------------------------------------
   always_comb begin
      logic mismatch;
      mismatch = 1'b0;
      next_st = '0;
      // Non-packet drives never look at the enable
      mismatch = start_req && is_packet_drive && check_enable
                 && (own_dir_in != drive_dir_in);
      if (mismatch) begin
         next_st.abort = 1'b1;
         next_st.err   = 1'b1;
      end else if (start_req) begin
         next_st.ok = 1'b1;
      end
   end

   // Pulses last one cycle, so the state is simply registered
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign start_ok      = st.ok;
   assign xfer_abort    = st.abort;
   assign seq_error_set = st.err;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   mismatch_abort_a: assert property (@(posedge ref_clk) disable iff (reset)
      start_req && is_packet_drive && check_enable
      && (own_dir_in != drive_dir_in)
      |=> xfer_abort && seq_error_set && !start_ok)
      else $error("direction mismatch not aborted");

   packet_match_a: assert property (@(posedge ref_clk) disable iff (reset)
      start_req && is_packet_drive && (own_dir_in == drive_dir_in)
      |=> start_ok && !seq_error_set)
      else $error("matching directions did not start");

   non_packet_a: assert property (@(posedge ref_clk) disable iff (reset)
      start_req && !is_packet_drive |=> start_ok && !xfer_abort)
      else $error("non-packet transfer was checked");

   mismatch_c: cover property (@(posedge ref_clk) disable iff (reset)
      xfer_abort);

endmodule

`default_nettype wire

// ### core/dic_pkg.sv
/*
 * Package for the drive interface configuration register block: the
 * register address, field positions, reset value, mode codes and state
 * encodings. It assumes the block sits on the MCU external data space
 * with a 16-bit byte address and 8-bit data.
 */
`default_nettype none

package dic_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [15:0] ADDR_CFG0   = 16'hF0D0;
   localparam logic [15:0] ADDR_BC0    = 16'hF0D6;
   localparam logic [15:0] ADDR_BC3    = 16'hF0D9;
   localparam logic [7:0]  CFG0_RESET  = 8'h00;
   localparam logic [7:0]  RDATA_IDLE  = 8'h00;

   // ------------------------------------------------------------------
   // Field positions in the configuration register
   // ------------------------------------------------------------------
   localparam int BIT_MODE_LO  = 0;
   localparam int BIT_MODE_HI  = 1;
   localparam int BIT_DIR_EN   = 2;
   localparam int BIT_WPA_EN   = 3;
   localparam int BIT_RSV_LO   = 4;
   localparam int BIT_RSV_HI   = 6;
   localparam int BIT_VIEW_SEL = 7;

   // ------------------------------------------------------------------
   // Transfer mode codes
   // ------------------------------------------------------------------
   localparam logic [1:0] MODE_PIO  = 2'h0;
   localparam logic [1:0] MODE_MDMA = 2'h1;
   localparam logic [1:0] MODE_RSV  = 2'h2;
   localparam logic [1:0] MODE_UDMA = 2'h3;

   // ------------------------------------------------------------------
   // Write-pending sequencer states
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      WP_IDLE,
      WP_MOVING,
      WP_PAUSED,
      WP_DRAIN
   } dic_wp_e;

endpackage

`default_nettype wire

// ### verification/dic_bridge_model.sv
/*
 * Bridge-side model for the drive interface config block: the two byte
 * counts, the drive type and directions, and the write transfer flow.
 * Assumes the bench strobes its controls at the falling edge and the
 * block's move, flush and abort outputs are one-cycle pulses.
 */
`default_nettype none

module dic_bridge_model #(
   parameter logic [31:0] USB_COUNT   = 32'h1122_3344,
   parameter logic [31:0] DRIVE_COUNT = 32'hA5B6_C7D8
) (
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        packet_sel,
   input  wire logic        dir_flip,
   input  wire logic        wr_go,
   input  wire logic        wr_done,
   output logic      [31:0] usb_byte_count,
   output logic      [31:0] drive_byte_count,
   output logic             is_packet_drive,
   output logic             own_dir_in,
   output logic             drive_dir_in,
   output logic             wr_xfer_active,
   output logic             last_packet_ready
);
   timeunit 1ns;
   timeprecision 1ns;

   // -----------------------------------------------------------------
   // Drive side levels
   // -----------------------------------------------------------------
   // Distinct counts so a wrong view or byte lane shows at once
   assign usb_byte_count   = USB_COUNT;
   assign drive_byte_count = DRIVE_COUNT;
   assign is_packet_drive  = packet_sel;
   assign own_dir_in       = 1'h1;
   assign drive_dir_in     = ~dir_flip;

   // -----------------------------------------------------------------
   // Write transfer flow
   // -----------------------------------------------------------------
   // Two packets move before the last one is ready; ends on a decision
   logic [1:0] moved;
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wr_xfer_active <= 1'h0;
         moved          <= 2'h0;
      end else if (wr_go) begin
         wr_xfer_active <= 1'h1;
         moved          <= 2'h0;
      end else if (wr_done) begin
         wr_xfer_active <= 1'h0;
      end else if (wr_xfer_active && moved != 2'h2) begin
         moved <= moved + 2'h1;
      end
   end
   assign last_packet_ready = wr_xfer_active && moved == 2'h2;

endmodule

`default_nettype wire

// ### verification/test_ata_interface_config_register.sv
/*
 * Self-checking bench for the drive interface config register block.
 * Assumes a 50 MHz ref_clk, inputs driven at the falling edge and the
 * bridge model on the far side.
 */
`default_nettype none

module test_ata_interface_config_register;
   timeunit 1ns;
   timeprecision 1ns;

   localparam logic [31:0] UCNT = 32'h1122_3344;
   localparam logic [31:0] DCNT = 32'hA5B6_C7D8;
   localparam logic [15:0] CFG  = dic_pkg::ADDR_CFG0;

   logic        ref_clk, reset, wdt_reset, usb_reset, xwr, xrd;
   logic [15:0] xaddr;
   logic [7:0]  xwdata, xrdata;
   logic        xrdata_valid, dma_direction_check_enable;
   logic [31:0] usb_byte_count, drive_byte_count;
   logic [1:0]  transfer_mode_select;
   logic        write_pending_abort_enable, byte_count_view_select;
   logic        dma_start_req, is_packet_drive, own_dir_in, drive_dir_in;
   logic        dma_start_ok, dma_xfer_abort, dma_sequence_error_flag;
   logic        wr_xfer_active, last_packet_ready, fw_move_req;
   logic        fw_abort_req, wr_pending, move_last_packet;
   logic        flush_last_packet, wr_xfer_abort;
   logic        packet_sel, dir_flip, wr_go, bad;
   int          fails, total_checks;

   dic_config_reg dut_u (.*);

   dic_bridge_model #(.USB_COUNT(UCNT), .DRIVE_COUNT(DCNT)) far_u (
      .ref_clk, .reset, .packet_sel, .dir_flip, .wr_go,
      .wr_done(move_last_packet | flush_last_packet),
      .usb_byte_count, .drive_byte_count, .is_packet_drive,
      .own_dir_in, .drive_dir_in, .wr_xfer_active, .last_packet_ready);

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic chk(input string w, input logic [31:0] e,
                      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // One write strobe; fields are settled by the next falling edge
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      xaddr  = a;
      xwdata = d;
      xwr    = 1'h1;
      @(negedge ref_clk);
      xwr = 1'h0;
   endtask

   // Valid stands one cycle only, so valid and the held data are looked at there
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(negedge ref_clk);
      xaddr = a;
      xrd   = 1'h1;
      @(negedge ref_clk);
      xrd = 1'h0;
      chk("xrdata_valid", 32'h1, 32'(xrdata_valid));
      chk("xrdata", 32'(e), 32'(xrdata));
   endtask

   // Bounded wait, since a lost pause would otherwise hang the run
   task automatic start_wr();
      int n;
      @(negedge ref_clk);
      wr_go = 1'h1;
      @(negedge ref_clk);
      wr_go = 1'h0;
      n = 0;
      while (wr_pending !== 1'h1) begin
         @(negedge ref_clk);
         n++;
         if (n > 20) begin
            chk("wr_pending wait", 32'h1, 32'h0);
            summarize();
         end
      end
   endtask

   task automatic fw(input logic ab);
      @(negedge ref_clk);
      fw_abort_req = ab;
      fw_move_req  = !ab;
      @(negedge ref_clk);
      fw_abort_req = 1'h0;
      fw_move_req  = 1'h0;
   endtask

   // -----------------------------------------------------------------
   // Clock and sequence
   // -----------------------------------------------------------------
   initial begin
      ref_clk = 1'h0;
      forever #10 ref_clk = ~ref_clk;
   end

   initial begin
      {wdt_reset, usb_reset, xwr, xrd, dma_start_req} = 5'h00;
      {fw_move_req, fw_abort_req, packet_sel, dir_flip, wr_go} = 5'h00;
      xaddr  = 16'h0000;
      xwdata = 8'h00;
      reset  = 1'h1;
      repeat (2) @(negedge ref_clk);
      reset = 1'h0;
      rd(CFG, 8'h00);
      chk("wr_pending", 32'h0, 32'(wr_pending));
      for (int m = 0; m < 4; m++) begin
         wr(CFG, 8'(m));
         chk("mode", 32'(m), 32'(transfer_mode_select));
         rd(CFG, 8'(m));
      end
      wr(CFG, 8'hFF);
      rd(CFG, 8'h8F);
      chk("fields", 32'h7, 32'({dma_direction_check_enable,
          write_pending_abort_enable, byte_count_view_select}));
      wr(CFG, 8'h0B);
      for (int i = 0; i < 4; i++)
         rd(dic_pkg::ADDR_BC0 + 16'(i), UCNT[8*i+:8]);
      rd(CFG, 8'h0B);
      wr(CFG, 8'h80 | 8'h0B);
      for (int i = 0; i < 4; i++)
         rd(dic_pkg::ADDR_BC0 + 16'(i), DCNT[8*i+:8]);
      rd(16'hF0D1, 8'h00);
      @(negedge ref_clk);
      usb_reset = 1'h1;
      @(negedge ref_clk);
      usb_reset = 1'h0;
      rd(CFG, 8'h8B);
      @(negedge ref_clk);
      wdt_reset = 1'h1;
      @(negedge ref_clk);
      wdt_reset = 1'h0;
      rd(CFG, 8'h00);
      chk("view", 32'h0, 32'(byte_count_view_select));
      // Every drive type, enable and direction pairing
      for (int k = 0; k < 8; k++) begin
         if (k % 4 == 0)
            wr(CFG, 8'(k));
         @(negedge ref_clk);
         packet_sel    = k[1];
         dir_flip      = k[0];
         dma_start_req = 1'h1;
         @(negedge ref_clk);
         dma_start_req = 1'h0;
         bad = k[2] & k[1] & k[0];
         chk("abort", 32'(bad), 32'(dma_xfer_abort));
         chk("seq_err", 32'(bad), 32'(dma_sequence_error_flag));
         chk("start_ok", 32'(!bad), 32'(dma_start_ok));
      end
      wr(CFG, 8'h08);
      start_wr();
      fw(1'h1);
      chk("flush", 32'h1, 32'(flush_last_packet));
      chk("wr_abort", 32'h1, 32'(wr_xfer_abort));
      chk("pending", 32'h0, 32'(wr_pending));
      wr(CFG, 8'h00);
      start_wr();
      fw(1'h1);
      chk("pending", 32'h1, 32'(wr_pending));
      chk("flush", 32'h0, 32'(flush_last_packet));
      fw(1'h0);
      chk("move", 32'h1, 32'(move_last_packet));
      chk("pending", 32'h0, 32'(wr_pending));
      repeat (3) @(negedge ref_clk);
      summarize();
   end

endmodule

`default_nettype wire
